// ===== rtl/smart_card_rx_error_flags.sv
// smart card serial unit: receive error flags, receiver and transmitter
`timescale 1ns/10ps

module smart_card_rx_error_flags (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        smart_card_select,
  input  wire logic                        clocked_sync_mode,
  input  wire logic                        receiver_enable_bit,
  input  wire logic                        transmitter_enable_bit,
  input  wire sc_flags_pkg::status_access_t status_access,
  output sc_flags_pkg::status_flags_t      status,
  output logic [7:0]                       receive_data_buffer,
  input  wire logic                        tx_valid,
  output logic                             tx_ready,
  input  wire logic [7:0]                  tx_data,
  input  wire logic                        line_in,
  output logic                             line_out,
  output logic                             line_oe_n,
  output logic                             rx_busy,
  output logic                             tx_busy
);

  // line synchroniser and filter
  logic line_s1_q;
  logic line_s2_q;
  logic line_s3_q;
  logic line_q;
  logic line_prev_q;

  // flags and their read-arming
  logic [3:0] flag_q;
  logic [3:0] flag_d;
  logic [3:0] armed_q;
  logic [3:0] armed_d;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [3:0] wr_bits;

  // receiver
  sc_flags_pkg::rx_state_t rx_state_q;
  sc_flags_pkg::rx_state_t rx_state_d;
  logic [15:0] rx_cnt_q;
  logic [15:0] rx_cnt_d;
  logic [3:0]  rx_bit_q;
  logic [3:0]  rx_bit_d;
  logic [7:0]  rx_sh_q;
  logic [7:0]  rx_sh_d;
  logic        rx_par_q;
  logic        rx_par_d;
  logic [7:0]  rx_buf_q;

  // transmitter
  sc_flags_pkg::tx_state_t tx_state_q;
  sc_flags_pkg::tx_state_t tx_state_d;
  logic [15:0] tx_cnt_q;
  logic [15:0] tx_cnt_d;
  logic [3:0]  tx_bit_q;
  logic [3:0]  tx_bit_d;
  logic [9:0]  tx_sh_q;
  logic [9:0]  tx_sh_d;
  logic        drive_low_q;

  logic       fifo_valid;
  logic [7:0] fifo_data;

  wire        rx_tick      = (rx_cnt_q == 16'h0000);
  wire        tx_tick      = (tx_cnt_q == 16'h0000);
  wire        line_fell    = line_prev_q & ~line_q;
  wire        err_blocked  = flag_q[sc_flags_pkg::FLAG_OVERRUN] |
                             flag_q[sc_flags_pkg::FLAG_PARITY];
  // half duplex: never listen to our own character
  wire        rx_allowed   = receiver_enable_bit & ~err_blocked &
                             (tx_state_q == sc_flags_pkg::TX_IDLE);
  wire        rx_start     = (rx_state_q == sc_flags_pkg::RX_IDLE) &
                             rx_allowed & line_fell;
  wire        rx_sample    = (rx_state_q == sc_flags_pkg::RX_BITS) & rx_tick;
  wire        rx_false_st  = rx_sample & (rx_bit_q == sc_flags_pkg::START_BIT) &
                             line_q;
  wire        rx_done      = rx_sample & (rx_bit_q == sc_flags_pkg::PARITY_BIT);
  // even parity over data and parity bit
  wire        parity_bad   = rx_par_q ^ line_q;
  wire        rx_overrun   = rx_done & flag_q[sc_flags_pkg::FLAG_RX_FULL];
  wire        rx_par_fail  = rx_done & parity_bad & ~rx_overrun;
  wire        rx_clean     = rx_done & ~parity_bad & ~rx_overrun;
  wire        rx_load      = rx_par_fail | rx_clean;
  wire        send_err_sig = rx_done & parity_bad & smart_card_select;
  wire        tx_halt      = clocked_sync_mode & err_blocked;
  wire        tx_take      = (tx_state_q == sc_flags_pkg::TX_IDLE) &
                             (rx_state_q == sc_flags_pkg::RX_IDLE) &
                             fifo_valid & transmitter_enable_bit & ~tx_halt;
  wire        tx_slot_low  = (tx_state_q == sc_flags_pkg::TX_SLOT) & tx_tick &
                             ~line_q & smart_card_select;
  wire        tx_par       = ^fifo_data;
  wire        drive_low_d  = ((tx_state_d == sc_flags_pkg::TX_BITS) &
                              ~tx_sh_d[0]) |
                             (rx_state_d == sc_flags_pkg::RX_DRIVE_ERR);

  stream_fifo #(
    .WIDTH (sc_flags_pkg::DATA_W),
    .DEPTH (sc_flags_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (tx_take),
    .out_data  (fifo_data)
  );

  // flag events; set always beats a clear in the same cycle
  assign flag_set[sc_flags_pkg::FLAG_OVERRUN] = rx_overrun;
  assign flag_set[sc_flags_pkg::FLAG_ERR_SIG] = tx_slot_low;
  assign flag_set[sc_flags_pkg::FLAG_PARITY]  = rx_par_fail;
  assign flag_set[sc_flags_pkg::FLAG_RX_FULL] = rx_clean;

  assign wr_bits  = status_access.wdata;
  // only a 0 written to a bit that was read as 1 clears it
  assign flag_clr = {4{status_access.wr}} & armed_q & ~wr_bits;
  // the receiver enable takes no part here, so disabling keeps every flag
  assign flag_d   = flag_set | (flag_q & ~flag_clr);
  assign armed_d  = (armed_q | ({4{status_access.rd}} & flag_q)) &
                    ~flag_clr & flag_d;

  assign status              = flag_q;
  assign receive_data_buffer = rx_buf_q;
  assign line_out            = 1'b0;
  assign line_oe_n           = ~drive_low_q;
  assign rx_busy             = (rx_state_q != sc_flags_pkg::RX_IDLE);
  assign tx_busy             = (tx_state_q != sc_flags_pkg::TX_IDLE);

  always_comb begin
    rx_state_d = rx_state_q;
    rx_cnt_d   = rx_tick ? 16'h0000 : rx_cnt_q - 16'h0001;
    rx_bit_d   = rx_bit_q;
    rx_sh_d    = rx_sh_q;
    rx_par_d   = rx_par_q;
    unique case (rx_state_q)
      sc_flags_pkg::RX_IDLE: begin
        if (rx_start) begin
          rx_state_d = sc_flags_pkg::RX_BITS;
          rx_cnt_d   = sc_flags_pkg::HALF_ETU_LAST;
          rx_bit_d   = sc_flags_pkg::START_BIT;
          rx_par_d   = 1'b0;
        end
      end
      sc_flags_pkg::RX_BITS: begin
        if (rx_tick) begin
          rx_cnt_d = sc_flags_pkg::ETU_LAST;
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q != sc_flags_pkg::START_BIT &&
              rx_bit_q != sc_flags_pkg::PARITY_BIT) begin
            rx_sh_d  = {line_q, rx_sh_q[7:1]};
            rx_par_d = rx_par_q ^ line_q;
          end
          if (rx_false_st) begin
            rx_state_d = sc_flags_pkg::RX_IDLE;
          end else if (rx_done) begin
            rx_state_d = send_err_sig ? sc_flags_pkg::RX_WAIT_SLOT :
                                        sc_flags_pkg::RX_IDLE;
          end
        end
      end
      sc_flags_pkg::RX_WAIT_SLOT: begin
        // from mid parity to the error slot is one unit
        if (rx_tick) begin
          rx_state_d = sc_flags_pkg::RX_DRIVE_ERR;
          rx_cnt_d   = sc_flags_pkg::ETU_LAST;
        end
      end
      sc_flags_pkg::RX_DRIVE_ERR: begin
        if (rx_tick) begin
          rx_state_d = sc_flags_pkg::RX_IDLE;
        end
      end
    endcase
    // a disabled receiver abandons its frame but not its flags
    if (!receiver_enable_bit) begin
      rx_state_d = sc_flags_pkg::RX_IDLE;
    end
  end

  always_comb begin
    tx_state_d = tx_state_q;
    tx_cnt_d   = tx_tick ? 16'h0000 : tx_cnt_q - 16'h0001;
    tx_bit_d   = tx_bit_q;
    tx_sh_d    = tx_sh_q;
    unique case (tx_state_q)
      sc_flags_pkg::TX_IDLE: begin
        if (tx_take) begin
          tx_state_d = sc_flags_pkg::TX_BITS;
          tx_cnt_d   = sc_flags_pkg::ETU_LAST;
          tx_bit_d   = sc_flags_pkg::START_BIT;
          tx_sh_d    = {tx_par, fifo_data, 1'b0};
        end
      end
      sc_flags_pkg::TX_BITS: begin
        if (tx_tick) begin
          tx_cnt_d = sc_flags_pkg::ETU_LAST;
          tx_bit_d = tx_bit_q + 4'h1;
          tx_sh_d  = {1'b1, tx_sh_q[9:1]};
          if (tx_bit_q == sc_flags_pkg::FRAME_BITS - 4'h1) begin
            tx_state_d = sc_flags_pkg::TX_SLOT;
          end
        end
      end
      sc_flags_pkg::TX_SLOT: begin
        // sample the middle of the card's error slot
        if (tx_tick) begin
          tx_state_d = sc_flags_pkg::TX_GUARD;
          tx_cnt_d   = sc_flags_pkg::ETU_LAST;
        end
      end
      sc_flags_pkg::TX_GUARD: begin
        if (tx_tick) begin
          tx_state_d = sc_flags_pkg::TX_IDLE;
        end
      end
    endcase
    if (!transmitter_enable_bit) begin
      tx_state_d = sc_flags_pkg::TX_IDLE;
      tx_sh_d    = {10{1'b1}};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_s1_q   <= 1'b1;
      line_s2_q   <= 1'b1;
      line_s3_q   <= 1'b1;
      line_q      <= 1'b1;
      line_prev_q <= 1'b1;
    end else begin
      line_s1_q   <= line_in;
      line_s2_q   <= line_s1_q;
      line_s3_q   <= line_s2_q;
      line_prev_q <= line_q;
      if (line_s2_q == line_s3_q) begin
        line_q <= line_s3_q;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q  <= sc_flags_pkg::FLAGS_RESET;
      armed_q <= 4'h0;
      rx_buf_q <= sc_flags_pkg::BUFFER_RESET;
    end else begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
      if (rx_load) begin
        rx_buf_q <= rx_sh_q;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_q <= sc_flags_pkg::RX_IDLE;
      rx_cnt_q   <= 16'h0000;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
      rx_par_q   <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_bit_q   <= rx_bit_d;
      rx_sh_q    <= rx_sh_d;
      rx_par_q   <= rx_par_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_q  <= sc_flags_pkg::TX_IDLE;
      tx_cnt_q    <= 16'h0000;
      tx_bit_q    <= 4'h0;
      tx_sh_q     <= 10'h3FF;
      drive_low_q <= 1'b0;
    end else begin
      tx_state_q  <= tx_state_d;
      tx_cnt_q    <= tx_cnt_d;
      tx_bit_q    <= tx_bit_d;
      tx_sh_q     <= tx_sh_d;
      drive_low_q <= drive_low_d;
    end
  end

endmodule : smart_card_rx_error_flags

// ===== rtl/sc_flags_pkg.sv
// shared constants, states and carriers for the smart card receive flags
package sc_flags_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 32;

  // clocks per elementary time unit; default is a plain value, adjust per card
  localparam logic [15:0] ETU_CLKS      = 16'h0174;
  localparam logic [15:0] ETU_LAST      = ETU_CLKS - 16'h0001;
  localparam logic [15:0] HALF_ETU_LAST = (ETU_CLKS >> 1) - 16'h0001;

  // start, eight data bits, parity
  localparam logic [3:0] FRAME_BITS  = 4'hA;
  localparam logic [3:0] PARITY_BIT  = 4'h9;
  localparam logic [3:0] START_BIT   = 4'h0;

  // flag positions inside the status vector
  localparam int unsigned FLAG_OVERRUN   = 3;
  localparam int unsigned FLAG_ERR_SIG   = 2;
  localparam int unsigned FLAG_PARITY    = 1;
  localparam int unsigned FLAG_RX_FULL   = 0;
  localparam logic [3:0]  FLAGS_RESET    = 4'h0;

  localparam logic [7:0] BUFFER_RESET = 8'h00;

  typedef struct packed {
    logic overrun_flag;
    logic error_signal_flag;
    logic parity_error_flag;
    logic receive_full_flag;
  } status_flags_t;

  typedef struct packed {
    logic          rd;
    logic          wr;
    status_flags_t wdata;
  } status_access_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_BITS,
    RX_WAIT_SLOT,
    RX_DRIVE_ERR
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_BITS,
    TX_SLOT,
    TX_GUARD
  } tx_state_t;

endpackage : sc_flags_pkg

// ===== rtl/stream_fifo.sv
// parameterised stream fifo with a registered output stage
`timescale 1ns/10ps
module stream_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      mem_cnt_q;
  logic [AW:0]      total;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  wire              push;
  wire              pop;
  wire              load;

  // the output register counts toward depth so full is honest
  assign total     = mem_cnt_q + {{AW{1'b0}}, out_valid_q};
  assign in_ready  = (total < (AW+1)'(DEPTH));
  assign push      = in_valid & in_ready;
  assign pop       = out_valid_q & out_ready;
  assign load      = (mem_cnt_q != '0) & (~out_valid_q | pop);
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      mem_cnt_q   <= '0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (load) begin
        rd_ptr_q   <= rd_ptr_q + 1'b1;
        out_data_q <= mem[rd_ptr_q];
      end
      if (push && !load) begin
        mem_cnt_q <= mem_cnt_q + 1'b1;
      end else if (load && !push) begin
        mem_cnt_q <= mem_cnt_q - 1'b1;
      end
      if (load) begin
        out_valid_q <= 1'b1;
      end else if (pop) begin
        out_valid_q <= 1'b0;
      end
    end
  end

endmodule : stream_fifo

// ===== sim/sc_flags_checker.sv
// concurrent checks on the ports of the smart card flag block
`timescale 1ns/10ps
module sc_flags_checker (
  input wire logic                         clk,
  input wire logic                         reset_n,
  input wire logic                         smart_card_select,
  input wire logic                         clocked_sync_mode,
  input wire logic                         receiver_enable_bit,
  input wire sc_flags_pkg::status_access_t status_access,
  input wire sc_flags_pkg::status_flags_t  status,
  input wire logic [7:0]                   receive_data_buffer,
  input wire logic                         line_oe_n,
  input wire logic                         rx_busy,
  input wire logic                         tx_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire ov = status.overrun_flag;
  wire es = status.error_signal_flag;
  wire pe = status.parity_error_flag;
  wire rf = status.receive_full_flag;
  // the error signal lasts a whole etu, eight cycles are enough to see it
  sequence s_err_low; !line_oe_n [*8]; endsequence
  property p_ovr_set; $rose(ov) |-> $past(rf) && $stable(receive_data_buffer);
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun set");
  property p_rx_hold; (ov || pe) && !rx_busy |=> !rx_busy; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx ran");
  property p_tx_halt;
    clocked_sync_mode && (ov || pe) && !tx_busy |=> !tx_busy;
  endproperty
  a_tx_halt: assert property (p_tx_halt) else $error("tx ran");
  property p_wr_one;
    ov && status_access.wr && status_access.wdata.overrun_flag |=> ov;
  endproperty
  a_wr_one: assert property (p_wr_one) else $error("one cleared");
  property p_clr_wr;
    $fell(ov) || $fell(es) || $fell(pe) |-> $past(status_access.wr);
  endproperty
  a_clr_wr: assert property (p_clr_wr) else $error("lost flag");
  property p_rx_off;
    $fell(receiver_enable_bit) && !status_access.wr && !rx_busy && !tx_busy
      |=> $stable(status);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx off");
  property p_es_set; $rose(es) |-> $past(tx_busy) && smart_card_select;
  endproperty
  a_es_set: assert property (p_es_set) else $error("es set");
  property p_par_set; $rose(pe) |-> !$rose(rf) && $past(rx_busy); endproperty
  a_par_set: assert property (p_par_set) else $error("pe set");
  property p_err_sig; $rose(pe) && smart_card_select |-> ##[360:380] s_err_low;
  endproperty
  a_err_sig: assert property (p_err_sig) else $error("no err signal");
  property p_full_set; $rose(rf) |-> $past(rx_busy) && !ov; endproperty
  a_full_set: assert property (p_full_set) else $error("rf set");
endmodule : sc_flags_checker

bind smart_card_rx_error_flags sc_flags_checker chk (
  .clk, .reset_n, .smart_card_select, .clocked_sync_mode,
  .receiver_enable_bit, .status_access, .status, .receive_data_buffer,
  .line_oe_n, .rx_busy, .tx_busy
);

// ===== sim/smart_card_model.sv
// behavioural smart card on the open-drain serial line
`timescale 1ns/10ps
module smart_card_model (
  input wire logic clk,
  input wire logic line,
  output logic     card_oe_n
);
  localparam int ETU = int'(sc_flags_pkg::ETU_CLKS);
  initial card_oe_n = 1'b1;
  // start, data lsb first, even parity unless bad is set
  task automatic send(input logic [7:0] b, input logic bad,
                      output logic nak);
    logic [9:0] f;
    f = {^b ^ bad, b, 1'b0};
    nak = 1'b0;
    for (int i = 0; i < 10; i++) begin
      card_oe_n <= f[i];
      repeat (ETU) @(posedge clk);
    end
    card_oe_n <= 1'b1;
    // long guard so the device error signal ends before the next start
    repeat (3 * ETU) begin
      @(posedge clk);
      nak = nak | ~line;
    end
  endtask : send
  // take a character from the device, sampling each data bit in its middle
  task automatic listen(output logic [7:0] b, input logic err);
    @(negedge line);
    repeat (ETU * 3 / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = line;
      repeat (ETU) @(posedge clk);
    end
    // a quarter unit before the error slot, margin on both sides of the sample
    repeat (ETU * 3 / 4) @(posedge clk);
    card_oe_n <= ~err;
    repeat (ETU * 3 / 2) @(posedge clk);
    card_oe_n <= 1'b1;
  endtask : listen
endmodule : smart_card_model

// ===== sim/tb_smart_card_rx_error_flags.sv
// self-checking bench for the smart card receive flag block
`timescale 1ns/10ps
module tb_smart_card_rx_error_flags;
  typedef struct packed {
    sc_flags_pkg::status_flags_t st;
    logic [7:0]                  data;
  } note_t;
  logic                         clk, reset_n, smart_card_select;
  logic                         clocked_sync_mode, receiver_enable_bit;
  logic                         transmitter_enable_bit, tx_valid, tx_ready;
  logic                         line_out, line_oe_n, card_oe_n;
  logic                         rx_busy, tx_busy, wr_q, bz_q;
  logic [7:0]                   tx_data, receive_data_buffer, last_rx, rnd;
  logic [7:0]                   tx_b, tx_seen;
  sc_flags_pkg::status_access_t status_access;
  sc_flags_pkg::status_flags_t  status;
  note_t                        q[$];
  note_t                        n;
  int                           n_fail, checked, cnt;
  // pulled-up open-drain line
  wire                          line = line_oe_n & card_oe_n;

  smart_card_rx_error_flags uut (
    .clk, .reset_n, .smart_card_select, .clocked_sync_mode,
    .receiver_enable_bit, .transmitter_enable_bit, .status_access, .status,
    .receive_data_buffer, .tx_valid, .tx_ready, .tx_data, .line_in(line),
    .line_out(), .line_oe_n, .rx_busy, .tx_busy
  );
  smart_card_model card (.clk, .line, .card_oe_n);

  always #5 clk = ~clk;

  function automatic logic [7:0] lfsr();
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    return rnd;
  endfunction : lfsr

  task automatic cmp_status(input sc_flags_pkg::status_flags_t e);
    checked++;
    if (status !== e) begin
      n_fail++;
      $display("unexpected status: expected %h seen %h", e, status);
    end
  endtask : cmp_status

  task automatic cmp_byte(input string nm, input logic [7:0] e, s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : cmp_byte

  // a result is a status write taking effect or a frame ending
  always @(posedge clk) begin
    wr_q <= status_access.wr;
    bz_q <= rx_busy | tx_busy;
    if (wr_q === 1'b1 || (bz_q === 1'b1 && (rx_busy | tx_busy) === 1'b0)) begin
      n = (q.size() != 0) ? q.pop_front() : 'x;
      cmp_status(n.st);
      cmp_byte("data", n.data, receive_data_buffer);
    end
  end

  task automatic note(input logic [3:0] st);
    q.push_back({st, last_rx});
  endtask : note

  task automatic sw_clear(input logic [3:0] w, input logic rd,
                          input logic [3:0] st);
    note(st);
    @(negedge clk);
    status_access = {rd, 1'b0, 4'h0};
    @(negedge clk);
    status_access = {1'b0, 1'b1, w};
    @(negedge clk);
    status_access = '0;
    @(negedge clk);
  endtask : sw_clear

  // st of zero marks a frame that must be refused
  task automatic rx(input logic bad, input logic [3:0] st, input logic take);
    logic [7:0] b;
    logic       nak;
    b = lfsr();
    if (take) last_rx = b;
    if (st != 4'h0) note(st);
    card.send(b, bad, nak);
    cmp_byte("err sig", 8'(bad & smart_card_select), 8'(nak));
  endtask : rx

  task automatic rx_disable_pulse();
    @(negedge clk);
    receiver_enable_bit = 1'b0;
    repeat (4) @(negedge clk);
    receiver_enable_bit = 1'b1;
  endtask : rx_disable_pulse

  task automatic push(input logic [7:0] d);
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data = d;
    while (tx_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask : push

  task automatic drain();
    while (q.size() != 0) @(negedge clk);
  endtask : drain

  task automatic end_of_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // about 45k cycles are needed; fifo frames are cut short on purpose
  initial begin
    #800000;
    n_fail++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    smart_card_select = 1'b1;
    clocked_sync_mode = 1'b0;
    receiver_enable_bit = 1'b1;
    transmitter_enable_bit = 1'b1;
    status_access = '0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rnd = 8'h09;
    last_rx = 8'h00;
    n_fail = 0;
    checked = 0;
    cnt = 0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    sw_clear(4'hF, 1'b1, 4'h0);
    $display("test reset done");
    rx(1'b0, 4'h1, 1'b1);
    rx(1'b0, 4'h9, 1'b0);
    rx(1'b0, 4'h0, 1'b0);
    sw_clear(4'h0, 1'b0, 4'h9);
    rx_disable_pulse();
    sw_clear(4'hF, 1'b1, 4'h9);
    sw_clear(4'h0, 1'b1, 4'h0);
    $display("test overrun done");
    rx(1'b1, 4'h2, 1'b1);
    rx(1'b0, 4'h0, 1'b0);
    rx_disable_pulse();
    sw_clear(4'h0, 1'b0, 4'h2);
    sw_clear(4'h0, 1'b1, 4'h0);
    rx(1'b0, 4'h1, 1'b1);
    sw_clear(4'h0, 1'b1, 4'h0);
    $display("test parity done");
    note(4'h4);
    tx_b = lfsr();
    push(tx_b);
    card.listen(tx_seen, 1'b1);
    cmp_byte("tx data", tx_b, tx_seen);
    note(4'h4);
    tx_b = lfsr();
    push(tx_b);
    card.listen(tx_seen, 1'b0);
    cmp_byte("tx data", tx_b, tx_seen);
    drain();
    rx_disable_pulse();
    sw_clear(4'h0, 1'b0, 4'h4);
    sw_clear(4'h0, 1'b1, 4'h0);
    $display("test error signal done");
    // normal mode: parity still flagged but no error signal on the line
    smart_card_select = 1'b0;
    rx(1'b1, 4'h2, 1'b1);
    @(negedge clk);
    clocked_sync_mode = 1'b1;
    while (tx_ready === 1'b1 && cnt < 40) begin
      push(lfsr());
      cnt++;
    end
    cmp_byte("fill count", 8'(sc_flags_pkg::FIFO_DEPTH), cnt[7:0]);
    sw_clear(4'h0, 1'b1, 4'h0);
    repeat (cnt) note(4'h0);
    // abort each frame right after it starts so the drain stays short
    while (q.size() != 0) begin
      @(negedge clk);
      transmitter_enable_bit = ~tx_busy;
    end
    transmitter_enable_bit = 1'b1;
    $display("test fifo done");
    end_of_test();
  end
endmodule : tb_smart_card_rx_error_flags
